// *** tb/pmr_chk.sv ***
/*
  pmr_chk: port-level assertions for pmr_top, bound into every instance.
  Assumes the single pclk domain and the open-drain link pins of pmr_top.
*/
`timescale 1ns/1ps
module pmr_chk
  import pmr_pkg::*;
#(
  parameter int HALF_CYC = PMR_LINK_HALF_CYC
)(
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb
  input wire logic [11:0] paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // link
  input wire logic        ps2_clk_i,
  input wire logic        ps2_clk_o,
  input wire logic        ps2_clk_oe,
  input wire logic        ps2_dat_i,
  input wire logic        ps2_dat_o,
  input wire logic        ps2_dat_oe
);
  // 20 to 30 kHz as half periods, scaled to the half period in use
  localparam int HALF_MIN = 3333 * HALF_CYC / PMR_LINK_HALF_CYC;
  localparam int HALF_MAX = 5000 * HALF_CYC / PMR_LINK_HALF_CYC;
  logic [15:0] low_cnt_reg;
  logic [15:0] high_cnt_reg;
  logic        acc;
  assign acc = psel && penable;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_cnt_reg <= 16'h0000;
    end else begin
      low_cnt_reg <= ps2_clk_oe ? low_cnt_reg + 16'h0001 : 16'h0000;
    end
  end
  // saturates so long idle gaps never wrap to a short count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      high_cnt_reg <= 16'hFFFF;
    end else if (ps2_clk_oe) begin
      high_cnt_reg <= 16'h0000;
    end else if (high_cnt_reg != 16'hFFFF) begin
      high_cnt_reg <= high_cnt_reg + 16'h0001;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_held: assert property ($past(presetn) |-> pready)
    else $error("pready low after reset");
  a_err_decode: assert property (acc && paddr[1:0] == 2'b00 |-> pslverr == (paddr[11:4] != 8'h00))
    else $error("pslverr decode wrong");
  a_err_reads_zero: assert property (acc && !pwrite && pslverr |-> prdata == 32'h0000_0000)
    else $error("refused read not zero");
  a_motion_reads_zero: assert property (acc && !pwrite && paddr == PMR_MOTION_OFS |-> prdata == 32'h0)
    else $error("motion read not zero");
  a_prdata_stands: assert property (acc |=> $stable(prdata))
    else $error("prdata changed after access");
  a_drive_low_only: assert property (ps2_clk_o == 1'b0 && ps2_dat_o == 1'b0)
    else $error("link pin driven high");
  a_clk_low_half: assert property ($fell(ps2_clk_oe) |-> low_cnt_reg >= HALF_MIN && low_cnt_reg <= HALF_MAX)
    else $error("link clock low half out of range");
  a_clk_high_half: assert property ($rose(ps2_clk_oe) |-> high_cnt_reg >= HALF_MIN)
    else $error("link clock high half too short");
  c_refused: cover property (acc && pslverr);
  c_motion: cover property (acc && pwrite && paddr == PMR_MOTION_OFS);
  c_pulse: cover property ($fell(ps2_clk_oe));
  c_data: cover property ($rose(ps2_dat_oe));
endmodule

bind pmr_top pmr_chk #(.HALF_CYC(LINK_HALF_CYC)) u_chk (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .ps2_clk_i(ps2_clk_i), .ps2_clk_o(ps2_clk_o), .ps2_clk_oe(ps2_clk_oe),
  .ps2_dat_i(ps2_dat_i), .ps2_dat_o(ps2_dat_o), .ps2_dat_oe(ps2_dat_oe)
);

// *** tb/pmr_host.sv ***
/*
  pmr_host: host end of the two-wire link; receives words, sends commands.
  Assumes pulled-up lines resolved by the bench from both parties' pulls.
*/
`timescale 1ns/1ps
module pmr_host #(
  parameter int HALF  = 4000,
  parameter int FIRST = 60000
)(
  // clock
  pclk,
  // line levels
  line_clk,
  line_dat,
  // pull-downs
  clk_pull,
  dat_pull
);
  input  wire logic pclk;
  input  wire logic line_clk;
  input  wire logic line_dat;
  output logic      clk_pull = 1'b0;
  output logic      dat_pull = 1'b0;
  // per-bit limit: four half periods plus synchroniser slack
  localparam int STEP = 4 * HALF + 16;
  // bounded, so a silent device cannot hang the host
  task automatic wait_fall(input int limit, output bit ok);
    logic prev;
    prev = line_clk;
    ok = 1'b0;
    for (int i = 0; i < limit && !ok; i++) begin
      @(posedge pclk);
      ok = prev && !line_clk;
      prev = line_clk;
    end
  endtask
  task automatic recv_byte(output logic [7:0] b, output bit ok);
    logic [10:0] w;
    bit          f;
    ok = 1'b1;
    for (int i = 0; i < 11; i++) begin
      wait_fall(i == 0 ? FIRST : STEP, f);
      ok = ok & f;
      w[i] = line_dat;
    end
    b = w[8:1];
    ok = ok & !w[0] & w[10] & (^w[9:1]);
  endtask
  task automatic send_byte(input logic [7:0] b, input bit bad, output bit ack);
    logic [9:0] fr;
    bit         ok;
    fr = {1'b1, ~^b ^ bad, b};
    @(posedge pclk);
    clk_pull <= 1'b1;
    repeat (2 * HALF) @(posedge pclk);
    dat_pull <= 1'b1;
    @(posedge pclk);
    clk_pull <= 1'b0;
    for (int i = 0; i < 10; i++) begin
      wait_fall(STEP, ok);
      dat_pull <= !fr[i];
    end
    wait_fall(STEP, ok);
    wait_fall(STEP, ok);
    // ack bit stands only through the last low half
    repeat (HALF / 2) @(posedge pclk);
    ack = ok && !line_dat;
  endtask
endmodule

// *** tb/testbench.sv ***
/*
  testbench: drives pmr_top over APB and talks to it through pmr_host.
  Assumes pull-ups on both link lines; a short report interval in sim.
*/
`timescale 1ns/1ps
module testbench;
  import pmr_pkg::*;
  // short report interval and link half period keep the run brief
  localparam int RCYC  = 1000;
  localparam int LHALF = 5;
  localparam int CEIL  = 60000;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic [7:0]  b;
  logic        pready, pslverr, err, clk_oe, dat_oe, clk_o, dat_o, h_clk, h_dat;
  logic        prev_line = 1'b1;
  int          fail_count, comparisons, cycles, falls, n;
  bit          ok;
  wire         line_clk = !(clk_oe | h_clk);
  wire         line_dat = !(dat_oe | h_dat);
  always #2.5 pclk = ~pclk;
  pmr_top #(.REPORT_CYC(RCYC), .LINK_HALF_CYC(LHALF)) dut (.pclk(pclk), .presetn(presetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ps2_clk_i(line_clk), .ps2_clk_o(clk_o),
    .ps2_clk_oe(clk_oe), .ps2_dat_i(line_dat), .ps2_dat_o(dat_o), .ps2_dat_oe(dat_oe));
  pmr_host #(.HALF(LHALF), .FIRST(3 * RCYC)) host (.pclk(pclk), .line_clk(line_clk),
    .line_dat(line_dat), .clk_pull(h_clk), .dat_pull(h_dat));
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    prev_line <= line_clk;
    if (prev_line && !line_clk) falls <= falls + 1;
    if (cycles == CEIL) begin
      fail_count++;
      $display("MISMATCH at %0t: timeout", $time);
      finish_test();
    end
  end
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e,
                        input string what);
    apb(a, 1'b0, 32'h0);
    check(rd & m, e, what);
  endtask
  task automatic get(input logic [7:0] e, input string what);
    host.recv_byte(b, ok);
    check({31'h0, ok}, 32'h1, "word framing");
    check({24'h0, b}, {24'h0, e}, what);
  endtask
  task automatic cmd(input logic [7:0] c, input bit bad, input logic [7:0] e);
    host.send_byte(c, bad, ok);
    check({31'h0, ok}, 32'h1, "ack bit");
    get(e, "answer byte");
  endtask
  task automatic report(input logic [7:0] s, input logic [7:0] h, input logic [7:0] v);
    get(s, "status byte");
    get(h, "horiz byte");
    get(v, "vert byte");
  endtask
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(PMR_STATUS_OFS, 32'hFFFFFFFF, {16'h0, PMR_RATE_RST, 8'h00}, "status reset");
    rd_chk(PMR_ACC_OFS, 32'hFFFFFFFF, 32'h0, "acc reset");
    apb(12'h010, 1'b0, 32'h0);
    check({31'h0, err}, 32'h1, "unmapped err");
    check(rd, 32'h0, "unmapped data");
    $display("test registers done");
    apb(PMR_CTRL_OFS, 1'b1, 32'h1);
    rd_chk(PMR_CTRL_OFS, 32'h3, 32'h1, "ctrl rw");
    repeat (2) apb(PMR_MOTION_OFS, 1'b1, 32'h0138_00FF);
    rd_chk(PMR_ACC_OFS, 32'h01FF_01FF, 32'h0100_00FF, "acc saturate");
    rd_chk(PMR_STATUS_OFS, 32'h0300_0000, 32'h0300_0000, "ovf flags");
    repeat (2 * RCYC) @(posedge pclk);
    check(32'(falls), 32'h0, "idle lines");
    $display("test idle done");
    cmd(PMR_CMD_STREAM, 1'b0, PMR_ACK);
    rd_chk(PMR_ACC_OFS, 32'hFFFFFFFF, 32'h0, "acc clear");
    rd_chk(PMR_STATUS_OFS, 32'h00FF_0001, 32'h00EA_0001, "stream on");
    // buttons first, so a single motion write forms the whole report
    apb(PMR_CTRL_OFS, 1'b1, 32'h3);
    cmd(PMR_CMD_ENABLE, 1'b0, PMR_ACK);
    apb(PMR_MOTION_OFS, 1'b1, 32'h0005_01FD);
    rd_chk(PMR_STATUS_OFS, 32'h2, 32'h2, "reporting on");
    report(8'h1B, 8'hFD, 8'h05);
    apb(PMR_MOTION_OFS, 1'b1, 32'h0000_0001);
    report(8'h0B, 8'h01, 8'h00);
    host.send_byte(PMR_CMD_RESEND, 1'b0, ok);
    check({31'h0, ok}, 32'h1, "resend ack bit");
    report(8'h0B, 8'h01, 8'h00);
    $display("test reports done");
    cmd(PMR_CMD_RATE, 1'b0, PMR_ACK);
    cmd(8'h28, 1'b0, PMR_ACK);
    rd_chk(PMR_STATUS_OFS, 32'h0000_FF00, 32'h0000_2800, "rate stored");
    cmd(8'h55, 1'b1, PMR_CMD_RESEND);
    cmd(PMR_CMD_DISABLE, 1'b0, PMR_ACK);
    rd_chk(PMR_STATUS_OFS, 32'h2, 32'h0, "reporting off");
    apb(PMR_MOTION_OFS, 1'b1, 32'h0000_0001);
    n = falls;
    repeat (2 * RCYC) @(posedge pclk);
    check(32'(falls), 32'(n), "no report");
    cmd(PMR_CMD_RESET, 1'b0, PMR_ACK);
    repeat (100) @(posedge pclk);
    rd_chk(PMR_STATUS_OFS, 32'h0000_FFFF, {16'h0, PMR_RATE_RST, 8'h00}, "defaults");
    $display("test commands done");
    finish_test();
  end
endmodule

// *** verilog/pmr_link_if.sv ***
/*
  pmr_link_if: byte path and line controls between the reporter and its link engine.
  Assumes both ends run on the same pclk; line levels are already synchronised.
*/
`timescale 1ns/1ps
interface pmr_link_if;
  logic [7:0] tx_data;
  logic       tx_valid;
  logic       tx_done;
  logic [7:0] rx_data;
  logic       rx_valid;
  logic       rx_err;
  logic       line_clk;
  logic       line_dat;
  logic       clk_oe;
  logic       dat_oe;

  modport phy (input tx_data, tx_valid, line_clk, line_dat,
               output tx_done, rx_data, rx_valid, rx_err, clk_oe, dat_oe);
  modport ctl (output tx_data, tx_valid, line_clk, line_dat,
               input tx_done, rx_data, rx_valid, rx_err, clk_oe, dat_oe);
endinterface

// *** verilog/pmr_phy.sv ***
/*
  pmr_phy: serial word engine; makes the link clock and shifts words out and in.
  Assumes synchronised line levels and a requester that holds tx_valid until tx_done.
*/
`timescale 1ns/1ps
module pmr_phy
  import pmr_pkg::*;
#(
  // half period in pclk cycles; shortened only to keep simulation brief
  parameter int HALF_CYC = PMR_LINK_HALF_CYC
)(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // link side
  pmr_link_if.phy  lk
);

  localparam logic [11:0] HALF_LAST = 12'(HALF_CYC - 1);
  localparam logic [3:0]  LAST_BIT  = 4'(PMR_WORD_BITS - 1);

  typedef enum logic [1:0] {P_IDLE, P_TX, P_RX} pmr_phy_e;

  pmr_phy_e    state_reg;
  logic [11:0] cnt_reg;
  logic        low_reg;
  logic [3:0]  bit_reg;
  logic [10:0] sh_reg;
  logic        half_end;

  assign half_end = (cnt_reg == HALF_LAST);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg   <= P_IDLE;
      cnt_reg     <= 12'h000;
      low_reg     <= 1'b0;
      bit_reg     <= 4'h0;
      sh_reg      <= 11'h000;
      lk.clk_oe   <= 1'b0;
      lk.dat_oe   <= 1'b0;
      lk.tx_done  <= 1'b0;
      lk.rx_valid <= 1'b0;
      lk.rx_err   <= 1'b0;
      lk.rx_data  <= 8'h00;
    end else begin
      lk.tx_done  <= 1'b0;
      lk.rx_valid <= 1'b0;
      lk.rx_err   <= 1'b0;
      cnt_reg     <= half_end ? 12'h000 : cnt_reg + 12'h001;
      unique case (state_reg)
        P_IDLE: begin
          cnt_reg <= 12'h000;
          low_reg <= 1'b0;
          bit_reg <= 4'h0;
          // host request to send: clock released, data pulled low
          if (lk.line_clk && !lk.line_dat) begin
            state_reg <= P_RX;
          // only start on an idle bus; clock low means inhibit
          end else if (lk.tx_valid && lk.line_clk && lk.line_dat) begin
            state_reg <= P_TX;
            sh_reg    <= {1'b1, ~^lk.tx_data, lk.tx_data, 1'b0};
            lk.dat_oe <= 1'b1;
          end
        end
        P_TX: begin
          if (half_end && !low_reg) begin
            // host grabbed the clock: give the bus back, word is retried
            if (!lk.line_clk) begin
              state_reg <= P_IDLE;
              lk.dat_oe <= 1'b0;
            end else begin
              lk.clk_oe <= 1'b1;
              low_reg   <= 1'b1;
            end
          end else if (half_end) begin
            lk.clk_oe <= 1'b0;
            low_reg   <= 1'b0;
            bit_reg   <= bit_reg + 4'h1;
            if (bit_reg == LAST_BIT) begin
              state_reg  <= P_IDLE;
              lk.dat_oe  <= 1'b0;
              lk.tx_done <= 1'b1;
            end else begin
              lk.dat_oe <= ~sh_reg[bit_reg + 4'h1];
            end
          end
        end
        P_RX: begin
          if (half_end && !low_reg) begin
            if (bit_reg <= LAST_BIT) begin
              sh_reg <= {lk.line_dat, sh_reg[10:1]};
            end
            lk.clk_oe <= 1'b1;
            low_reg   <= 1'b1;
          end else if (half_end) begin
            lk.clk_oe <= 1'b0;
            low_reg   <= 1'b0;
            bit_reg   <= bit_reg + 4'h1;
            if (bit_reg == LAST_BIT) begin
              lk.dat_oe <= 1'b1;
            end else if (bit_reg > LAST_BIT) begin
              state_reg  <= P_IDLE;
              lk.dat_oe  <= 1'b0;
              lk.rx_data <= sh_reg[8:1];
              if (!sh_reg[0] && sh_reg[10] && (^sh_reg[9:1])) begin
                lk.rx_valid <= 1'b1;
              end else begin
                lk.rx_err <= 1'b1;
              end
            end
          end
        end
      endcase
    end
  end

endmodule

// *** verilog/pmr_pkg.sv ***
/*
  pmr_pkg: constants shared by the pointing-device reporter and its link engine.
  Assumes a 200 MHz pclk; link timing counts are derived from it here.
*/
package pmr_pkg;

  // register byte offsets
  localparam logic [11:0] PMR_CTRL_OFS   = 12'h000;
  localparam logic [11:0] PMR_MOTION_OFS = 12'h004;
  localparam logic [11:0] PMR_STATUS_OFS = 12'h008;
  localparam logic [11:0] PMR_ACC_OFS    = 12'h00C;

  // field positions
  localparam int PMR_CTRL_LEFT_BIT  = 0;
  localparam int PMR_CTRL_RIGHT_BIT = 1;
  localparam int PMR_MOT_DX_LSB     = 0;
  localparam int PMR_MOT_DY_LSB     = 16;
  localparam int PMR_ST_STREAM_BIT  = 0;
  localparam int PMR_ST_ENABLE_BIT  = 1;
  localparam int PMR_ST_BUSY_BIT    = 2;
  localparam int PMR_ST_RATE_LSB    = 8;
  localparam int PMR_ST_CMD_LSB     = 16;
  localparam int PMR_ST_HOV_BIT     = 24;
  localparam int PMR_ST_VOV_BIT     = 25;

  // reset values
  localparam logic [7:0] PMR_RATE_RST = 8'h64;

  // host commands and device answers
  localparam logic [7:0] PMR_CMD_STREAM  = 8'hEA;
  localparam logic [7:0] PMR_CMD_ENABLE  = 8'hF4;
  localparam logic [7:0] PMR_CMD_DISABLE = 8'hF5;
  localparam logic [7:0] PMR_CMD_RATE    = 8'hF3;
  localparam logic [7:0] PMR_CMD_RESEND  = 8'hFE;
  localparam logic [7:0] PMR_CMD_RESET   = 8'hFF;
  localparam logic [7:0] PMR_ACK         = 8'hFA;

  // link word: start, 8 data, parity, stop
  localparam int PMR_WORD_BITS = 11;

  // timing
  localparam int PMR_CLK_PERIOD_NS = 5;
  localparam int PMR_LINK_HALF_NS  = 20000;
  localparam int PMR_LINK_HALF_CYC = (PMR_LINK_HALF_NS + PMR_CLK_PERIOD_NS - 1)
                                     / PMR_CLK_PERIOD_NS;
  localparam int PMR_REPORT_NS     = 50000000;
  localparam int PMR_REPORT_CYC    = PMR_REPORT_NS / PMR_CLK_PERIOD_NS;

endpackage

// *** verilog/pmr_top.sv ***
/*
  pmr_top: pointing-device reporter seen by host logic over a two-wire link,
  with an APB register port through which movement and buttons are fed in.
  Assumes open-drain pins resolved outside; line inputs are asynchronous.
*/
// Decided for this implementation: the register addresses and the APB register port.
`timescale 1ns/1ps
module pmr_top
  import pmr_pkg::*;
#(
  parameter int REPORT_CYC    = PMR_REPORT_CYC,
  parameter int LINK_HALF_CYC = PMR_LINK_HALF_CYC
)(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // link pins
  input  wire logic        ps2_clk_i,
  output logic             ps2_clk_o,
  output logic             ps2_clk_oe,
  input  wire logic        ps2_dat_i,
  output logic             ps2_dat_o,
  output logic             ps2_dat_oe
);

  typedef enum logic [0:0] {M_IDLE, M_SEND} pmr_main_e;

  pmr_link_if lk ();

  pmr_main_e   state_reg;
  logic [1:0]  clk_sync_reg;
  logic [1:0]  dat_sync_reg;
  logic [1:0]  btn_reg;
  logic        moved_reg;
  logic [8:0]  acc_x_reg;
  logic [8:0]  acc_y_reg;
  logic        hov_reg;
  logic        vov_reg;
  logic        stream_reg;
  logic        enable_reg;
  logic [7:0]  rate_reg;
  logic        rate_wait_reg;
  logic        reset_after_reg;
  logic [7:0]  cmd_reg;
  logic        cmd_err_reg;
  logic        cmd_pend_reg;
  logic [7:0]  pkt_reg [3];
  logic [1:0]  len_reg;
  logic [1:0]  idx_reg;
  logic [23:0] tick_cnt_reg;
  logic        tick;

  logic        wr_en;
  logic        rd_setup;
  logic        take_cmd;
  logic        take_report;
  logic        send_end;
  logic        clr_cnt;
  logic [9:0]  sum_x;
  logic [9:0]  sum_y;
  logic [8:0]  acc_x_next;
  logic [8:0]  acc_y_next;
  logic        hov_next;
  logic        vov_next;

  // two-stage synchronisers on the pin inputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_sync_reg <= 2'b11;
      dat_sync_reg <= 2'b11;
    end else begin
      clk_sync_reg <= {clk_sync_reg[0], ps2_clk_i};
      dat_sync_reg <= {dat_sync_reg[0], ps2_dat_i};
    end
  end

  assign lk.line_clk = clk_sync_reg[1];
  assign lk.line_dat = dat_sync_reg[1];

  // pins only ever pulled low; released lines float high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ps2_clk_o  <= 1'b0;
      ps2_dat_o  <= 1'b0;
      ps2_clk_oe <= 1'b0;
      ps2_dat_oe <= 1'b0;
    end else begin
      ps2_clk_o  <= 1'b0;
      ps2_dat_o  <= 1'b0;
      ps2_clk_oe <= lk.clk_oe;
      ps2_dat_oe <= lk.dat_oe;
    end
  end

  // apb: zero wait states, read data formed in the setup cycle
  assign wr_en    = psel && penable && pwrite;
  assign rd_setup = psel && !penable;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= 1'b1;
      if (rd_setup) begin
        prdata  <= 32'h0000_0000;
        pslverr <= 1'b0;
        unique case (paddr)
          PMR_CTRL_OFS: begin
            prdata[PMR_CTRL_LEFT_BIT]  <= btn_reg[0];
            prdata[PMR_CTRL_RIGHT_BIT] <= btn_reg[1];
          end
          PMR_MOTION_OFS: begin
            prdata <= 32'h0000_0000;
          end
          PMR_STATUS_OFS: begin
            prdata[PMR_ST_STREAM_BIT]                <= stream_reg;
            prdata[PMR_ST_ENABLE_BIT]                <= enable_reg;
            prdata[PMR_ST_BUSY_BIT]                  <= (state_reg == M_SEND);
            prdata[PMR_ST_RATE_LSB +: 8]             <= rate_reg;
            prdata[PMR_ST_CMD_LSB +: 8]              <= cmd_reg;
            prdata[PMR_ST_HOV_BIT]                   <= hov_reg;
            prdata[PMR_ST_VOV_BIT]                   <= vov_reg;
          end
          PMR_ACC_OFS: begin
            prdata[PMR_MOT_DX_LSB +: 9] <= acc_x_reg;
            prdata[PMR_MOT_DY_LSB +: 9] <= acc_y_reg;
          end
          default: begin
            pslverr <= 1'b1;
          end
        endcase
      end
    end
  end

  // buttons held as levels; a write to ctrl or motion counts as activity to report
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      btn_reg <= 2'b00;
    end else if (wr_en && paddr == PMR_CTRL_OFS) begin
      btn_reg <= {pwdata[PMR_CTRL_RIGHT_BIT], pwdata[PMR_CTRL_LEFT_BIT]};
    end
  end

  // motion: each write adds signed steps; counts build up between reports
  // so faster motion gives larger values; a clear and a write in one cycle
  // keep the write
  assign clr_cnt = take_report || (send_end && reset_after_reg) ||
                   (take_cmd && !cmd_err_reg && !rate_wait_reg &&
                    (cmd_reg == PMR_CMD_STREAM || cmd_reg == PMR_CMD_ENABLE ||
                     cmd_reg == PMR_CMD_DISABLE));

  always_comb begin
    acc_x_next = clr_cnt ? 9'h000 : acc_x_reg;
    acc_y_next = clr_cnt ? 9'h000 : acc_y_reg;
    hov_next   = clr_cnt ? 1'b0 : hov_reg;
    vov_next   = clr_cnt ? 1'b0 : vov_reg;
    sum_x      = {acc_x_next[8], acc_x_next} + {pwdata[PMR_MOT_DX_LSB + 8],
                                                pwdata[PMR_MOT_DX_LSB +: 9]};
    sum_y      = {acc_y_next[8], acc_y_next} + {pwdata[PMR_MOT_DY_LSB + 8],
                                                pwdata[PMR_MOT_DY_LSB +: 9]};
    if (wr_en && paddr == PMR_MOTION_OFS) begin
      // right and up arrive as positive steps and stay positive
      if (sum_x[9] != sum_x[8]) begin
        acc_x_next = sum_x[9] ? 9'h100 : 9'h0FF;
        hov_next   = 1'b1;
      end else begin
        acc_x_next = sum_x[8:0];
      end
      if (sum_y[9] != sum_y[8]) begin
        acc_y_next = sum_y[9] ? 9'h100 : 9'h0FF;
        vov_next   = 1'b1;
      end else begin
        acc_y_next = sum_y[8:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_x_reg <= 9'h000;
      acc_y_reg <= 9'h000;
      hov_reg   <= 1'b0;
      vov_reg   <= 1'b0;
      moved_reg <= 1'b0;
    end else begin
      acc_x_reg <= acc_x_next;
      acc_y_reg <= acc_y_next;
      hov_reg   <= hov_next;
      vov_reg   <= vov_next;
      if (wr_en && (paddr == PMR_MOTION_OFS || paddr == PMR_CTRL_OFS)) begin
        moved_reg <= 1'b1;
      end else if (clr_cnt) begin
        moved_reg <= 1'b0;
      end
    end
  end

  // report interval timer, free running
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_reg <= 24'h00_0000;
    end else if (tick) begin
      tick_cnt_reg <= 24'h00_0000;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 24'h00_0001;
    end
  end

  assign tick = (tick_cnt_reg == 24'(REPORT_CYC - 1));

  // incoming bytes; a new arrival wins over consumption of the previous byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_reg      <= 8'h00;
      cmd_err_reg  <= 1'b0;
      cmd_pend_reg <= 1'b0;
    end else if (lk.rx_valid || lk.rx_err) begin
      cmd_reg      <= lk.rx_data;
      cmd_err_reg  <= lk.rx_err;
      cmd_pend_reg <= 1'b1;
    end else if (take_cmd) begin
      cmd_pend_reg <= 1'b0;
    end
  end

  assign take_cmd    = (state_reg == M_IDLE) && cmd_pend_reg;
  assign take_report = (state_reg == M_IDLE) && !cmd_pend_reg && tick &&
                       stream_reg && enable_reg && moved_reg;
  assign send_end    = (state_reg == M_SEND) && lk.tx_done &&
                       (idx_reg == len_reg - 2'd1 || cmd_pend_reg);

  // mode state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stream_reg      <= 1'b0;
      enable_reg      <= 1'b0;
      rate_reg        <= PMR_RATE_RST;
      rate_wait_reg   <= 1'b0;
      reset_after_reg <= 1'b0;
    end else if (send_end && reset_after_reg) begin
      // ack is out; now fall back to power-up defaults
      stream_reg      <= 1'b0;
      enable_reg      <= 1'b0;
      rate_reg        <= PMR_RATE_RST;
      rate_wait_reg   <= 1'b0;
      reset_after_reg <= 1'b0;
    end else if (take_cmd && !cmd_err_reg) begin
      if (rate_wait_reg) begin
        rate_reg      <= cmd_reg;
        rate_wait_reg <= 1'b0;
      end else begin
        unique case (cmd_reg)
          PMR_CMD_STREAM:  stream_reg      <= 1'b1;
          PMR_CMD_ENABLE:  enable_reg      <= 1'b1;
          PMR_CMD_DISABLE: enable_reg      <= 1'b0;
          PMR_CMD_RATE:    rate_wait_reg   <= 1'b1;
          PMR_CMD_RESET:   reset_after_reg <= 1'b1;
          default: begin
          end
        endcase
      end
    end
  end

  // packet buffer; kept after sending so it can be sent again
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pkt_reg[0] <= 8'h00;
      pkt_reg[1] <= 8'h00;
      pkt_reg[2] <= 8'h00;
      len_reg    <= 2'd1;
    end else if (take_report) begin
      pkt_reg[0] <= {vov_reg, hov_reg, acc_y_reg[8], acc_x_reg[8],
                     1'b1, 1'b0, btn_reg};
      pkt_reg[1] <= acc_x_reg[7:0];
      pkt_reg[2] <= acc_y_reg[7:0];
      len_reg    <= 2'd3;
    end else if (take_cmd && (cmd_err_reg || rate_wait_reg ||
                              cmd_reg != PMR_CMD_RESEND)) begin
      // a damaged byte asks the host to send again
      pkt_reg[0] <= cmd_err_reg ? PMR_CMD_RESEND : PMR_ACK;
      len_reg    <= 2'd1;
    end
  end

  // sender: words of one packet go out back to back
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= M_IDLE;
      idx_reg   <= 2'd0;
    end else begin
      unique case (state_reg)
        M_IDLE: begin
          idx_reg <= 2'd0;
          if (take_cmd || take_report) begin
            state_reg <= M_SEND;
          end
        end
        M_SEND: begin
          // a fresh host byte cuts the rest of a packet short
          if (send_end) begin
            state_reg <= M_IDLE;
          end else if (lk.tx_done) begin
            idx_reg <= idx_reg + 2'd1;
          end
        end
      endcase
    end
  end

  assign lk.tx_valid = (state_reg == M_SEND);
  assign lk.tx_data  = pkt_reg[idx_reg];

  pmr_phy #(.HALF_CYC(LINK_HALF_CYC)) u_phy (
    .pclk    (pclk),
    .presetn (presetn),
    .lk      (lk.phy)
  );

endmodule
